// ==== rtl/pfm_port_mux.sv ====
// function mux, group-two gpio registers and wake detect for pins 1.3, 1.4 and 2.0-2.5
//
// How it works
// - pin 1.3 select is bits 2:0, reset zero; 000 gpio, 001 path-two pulse
// - pin 1.3 code 010 routes the pin to uart five receive
// - pin 1.3 code 011 makes the pin io interrupt input zero
// - pin 1.3 code 100 drives path-one energy pulse onto the pin
// - pin 1.3 code 101 drives the rtc second pulse, calibrated upstream
// - pin 1.3 code 110 drives the divided pll pulse
// - pin 1.4 select is bits 1:0; 00 gpio, 01 divided pll pulse
// - pin 1.4 code 10 drives uart five transmit, 11 is interrupt input one
// - six group-two pins; in gpio mode enables decide the pin state
// - group-two output disable, active high per pin, resets all ones
// - group-two input enable, active high per pin, resets all zeros
// - group-two output value drives the pins, resets all ones
// - pin level register follows enabled pins whatever the function, resets zero
// - power gate bit three idles gpio pins only, not special functions
// - pin 2.0: 00 gpio, 01 osc waveform, 10 uart four rx, 11 timer two
// - pin 2.1: 00 gpio, 01 reserved, 10 uart four tx, 11 timer zero
// - with input enabled during sleep, an edge held four osc cycles wakes
//
// Implementation choice: the APB interface to the registers.
module pfm_port_mux #(
  parameter int unsigned OSC_DIV = pfm_pkg::OSC_DIV_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // group-one gpio controls for pins 1.3 (bit 0) and 1.4 (bit 1)
  input wire logic [1:0] p1_out_disable,
  input wire logic [1:0] p1_in_enable,
  input wire logic [1:0] p1_out_value,
  output logic [1:0] p1_pin_level,
  // pads: bit 0 pin 1.3, bit 1 pin 1.4
  input wire logic [1:0] p1_pad_in,
  output logic [1:0] p1_pad_out,
  output logic [1:0] p1_pad_oe,
  // pads: bit n pin 2.n
  input wire logic [5:0] p2_pad_in,
  output logic [5:0] p2_pad_out,
  output logic [5:0] p2_pad_oe,
  // peripheral sources
  input wire logic energy_path1_pulse,
  input wire logic energy_path2_pulse,
  input wire logic second_pulse_out,
  input wire logic divided_pll_pulse,
  input wire logic reference_clock_waveform,
  input wire logic uart_five_transmit,
  input wire logic uart_four_transmit,
  // peripheral sinks
  output logic uart_five_receive,
  output logic uart_four_receive,
  output logic timer_two_ext_input,
  output logic timer_zero_ext_input,
  output logic [1:0] io_irq_input,
  // sleep and wake
  input wire logic sleep_active,
  output logic wake_pulse
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] word_index(input logic [17:0] addr);
    word_index = addr[17:2];
  endfunction

  function automatic logic drive_gpio(input logic out_dis, input logic gated);
    // gating only blanks pins left in gpio mode
    drive_gpio = ~out_dis & ~gated;
  endfunction

  // ==========================================================
  // registers
  logic [5:0] g2_out_dis_q;
  logic [5:0] g2_in_en_q;
  logic [5:0] g2_out_val_q;
  logic [5:0] g2_level_q;
  logic [2:0] p13_sel_q;
  logic [1:0] p14_sel_q;
  logic [1:0] p20_sel_q;
  logic [1:0] p21_sel_q;
  logic [7:0] pwr_ctrl_q;
  logic [1:0] p1_level_q;
  logic gate_on;

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wr_commit;
  logic rd_launch;
  logic [15:0] acc_idx;
  logic idx_hit;
  logic [31:0] rd_word;

  assign gate_on = pwr_ctrl_q[pfm_pkg::GATE_BIT];
  assign acc_idx = word_index(paddr);
  // pready goes high one cycle into the access phase; the write lands at the next edge, where pready is sampled
  assign rd_launch = psel & penable & ~pready_q;
  assign wr_commit = psel & penable & pready_q & pwrite & idx_hit;

  always_comb
  begin
    idx_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (acc_idx)
      pfm_pkg::IDX_G2_OUT_DIS: rd_word = {26'h000_0000, g2_out_dis_q};
      pfm_pkg::IDX_G2_IN_EN: rd_word = {26'h000_0000, g2_in_en_q};
      pfm_pkg::IDX_G2_OUT_VAL: rd_word = {26'h000_0000, g2_out_val_q};
      pfm_pkg::IDX_G2_LEVEL: rd_word = {26'h000_0000, g2_level_q};
      pfm_pkg::IDX_P13_SEL: rd_word = {29'h0000_0000, p13_sel_q};
      pfm_pkg::IDX_P14_SEL: rd_word = {30'h0000_0000, p14_sel_q};
      pfm_pkg::IDX_P20_SEL: rd_word = {30'h0000_0000, p20_sel_q};
      pfm_pkg::IDX_P21_SEL: rd_word = {30'h0000_0000, p21_sel_q};
      pfm_pkg::IDX_PWR_CTRL: rd_word = {24'h00_0000, pwr_ctrl_q};
      default: idx_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // apb answer
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= rd_launch;
      if (rd_launch)
      begin
        pslverr_q <= ~idx_hit;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end
      else
      begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // software-written registers
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      g2_out_dis_q <= pfm_pkg::RST_G2_OUT_DIS;
      g2_in_en_q <= pfm_pkg::RST_G2_IN_EN;
      g2_out_val_q <= pfm_pkg::RST_G2_OUT_VAL;
      p13_sel_q <= pfm_pkg::RST_P13_SEL;
      p14_sel_q <= pfm_pkg::RST_PX_SEL;
      p20_sel_q <= pfm_pkg::RST_PX_SEL;
      p21_sel_q <= pfm_pkg::RST_PX_SEL;
      pwr_ctrl_q <= pfm_pkg::RST_PWR_CTRL;
    end
    else if (wr_commit)
    begin
      case (acc_idx)
        pfm_pkg::IDX_G2_OUT_DIS: g2_out_dis_q <= pwdata[5:0];
        pfm_pkg::IDX_G2_IN_EN: g2_in_en_q <= pwdata[5:0];
        pfm_pkg::IDX_G2_OUT_VAL: g2_out_val_q <= pwdata[5:0];
        pfm_pkg::IDX_P13_SEL: p13_sel_q <= pwdata[2:0];
        pfm_pkg::IDX_P14_SEL: p14_sel_q <= pwdata[1:0];
        pfm_pkg::IDX_P20_SEL: p20_sel_q <= pwdata[1:0];
        pfm_pkg::IDX_P21_SEL: p21_sel_q <= pwdata[1:0];
        pfm_pkg::IDX_PWR_CTRL: pwr_ctrl_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // pad input synchronisers: bits 1:0 group one, 7:2 group two
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sync3_q;
  logic [7:0] pin_q;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
    end
    else
    begin
      sync1_q <= {p2_pad_in, p1_pad_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a change is accepted only once the second and third stages agree
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pin_q <= 8'h00;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (sync2_q[i] == sync3_q[i])
          pin_q[i] <= sync3_q[i];
      end
    end
  end

  // ==========================================================
  // level registers: update only while enabled, so idle inputs do not toggle
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      g2_level_q <= pfm_pkg::RST_G2_LEVEL;
      p1_level_q <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < pfm_pkg::G2_PINS; i++)
      begin
        if (g2_in_en_q[i])
          g2_level_q[i] <= pin_q[i + 2];
      end
      for (int j = 0; j < 2; j++)
      begin
        if (p1_in_enable[j])
          p1_level_q[j] <= pin_q[j];
      end
    end
  end

  // ==========================================================
  // function routing
  logic [1:0] p1_out_d;
  logic [1:0] p1_oe_d;
  logic [5:0] p2_out_d;
  logic [5:0] p2_oe_d;
  logic u5_rx_d;
  logic u4_rx_d;
  logic t2_d;
  logic t0_d;
  logic [1:0] irq_d;

  always_comb
  begin
    // gpio defaults; reserved codes fall through to these
    for (int i = 0; i < 2; i++)
    begin
      p1_out_d[i] = p1_out_value[i];
      p1_oe_d[i] = drive_gpio(p1_out_disable[i], gate_on);
    end
    for (int i = 0; i < pfm_pkg::G2_PINS; i++)
    begin
      p2_out_d[i] = g2_out_val_q[i];
      p2_oe_d[i] = drive_gpio(g2_out_dis_q[i], gate_on);
    end
    // uart lines idle high when not routed
    u5_rx_d = 1'b1;
    u4_rx_d = 1'b1;
    t2_d = 1'b0;
    t0_d = 1'b0;
    irq_d = 2'h0;

    case (pfm_pkg::pfm_p13_code_t'(p13_sel_q))
      pfm_pkg::P13_GPIO: ;
      pfm_pkg::P13_E2_PULSE:
      begin
        p1_out_d[0] = energy_path2_pulse;
        p1_oe_d[0] = 1'b1;
      end
      pfm_pkg::P13_UART5_RX:
      begin
        u5_rx_d = pin_q[0];
        p1_oe_d[0] = 1'b0;
      end
      pfm_pkg::P13_IRQ0:
      begin
        irq_d[0] = pin_q[0];
        p1_oe_d[0] = 1'b0;
      end
      pfm_pkg::P13_E1_PULSE:
      begin
        p1_out_d[0] = energy_path1_pulse;
        p1_oe_d[0] = 1'b1;
      end
      pfm_pkg::P13_SECOND:
      begin
        p1_out_d[0] = second_pulse_out;
        p1_oe_d[0] = 1'b1;
      end
      pfm_pkg::P13_PLL_DIV:
      begin
        p1_out_d[0] = divided_pll_pulse;
        p1_oe_d[0] = 1'b1;
      end
      default: ;
    endcase

    case (pfm_pkg::pfm_p14_code_t'(p14_sel_q))
      pfm_pkg::P14_GPIO: ;
      pfm_pkg::P14_PLL_DIV:
      begin
        p1_out_d[1] = divided_pll_pulse;
        p1_oe_d[1] = 1'b1;
      end
      pfm_pkg::P14_UART5_TX:
      begin
        p1_out_d[1] = uart_five_transmit;
        p1_oe_d[1] = 1'b1;
      end
      pfm_pkg::P14_IRQ1:
      begin
        irq_d[1] = pin_q[1];
        p1_oe_d[1] = 1'b0;
      end
      default: ;
    endcase

    case (pfm_pkg::pfm_p20_code_t'(p20_sel_q))
      pfm_pkg::P20_GPIO: ;
      pfm_pkg::P20_OSC:
      begin
        p2_out_d[0] = reference_clock_waveform;
        p2_oe_d[0] = 1'b1;
      end
      pfm_pkg::P20_UART4_RX:
      begin
        u4_rx_d = pin_q[2];
        p2_oe_d[0] = 1'b0;
      end
      pfm_pkg::P20_TIMER2:
      begin
        t2_d = pin_q[2];
        p2_oe_d[0] = 1'b0;
      end
      default: ;
    endcase

    case (pfm_pkg::pfm_p21_code_t'(p21_sel_q))
      pfm_pkg::P21_UART4_TX:
      begin
        p2_out_d[1] = uart_four_transmit;
        p2_oe_d[1] = 1'b1;
      end
      pfm_pkg::P21_TIMER0:
      begin
        t0_d = pin_q[3];
        p2_oe_d[1] = 1'b0;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // registered pad and peripheral outputs
  logic [1:0] p1_out_q;
  logic [1:0] p1_oe_q;
  logic [5:0] p2_out_q;
  logic [5:0] p2_oe_q;
  logic u5_rx_q;
  logic u4_rx_q;
  logic t2_q;
  logic t0_q;
  logic [1:0] irq_q;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      p1_out_q <= 2'h3;
      p1_oe_q <= 2'h0;
      p2_out_q <= pfm_pkg::RST_G2_OUT_VAL;
      p2_oe_q <= 6'h00;
      u5_rx_q <= 1'b1;
      u4_rx_q <= 1'b1;
      t2_q <= 1'b0;
      t0_q <= 1'b0;
      irq_q <= 2'h0;
    end
    else
    begin
      p1_out_q <= p1_out_d;
      p1_oe_q <= p1_oe_d;
      p2_out_q <= p2_out_d;
      p2_oe_q <= p2_oe_d;
      u5_rx_q <= u5_rx_d;
      u4_rx_q <= u4_rx_d;
      t2_q <= t2_d;
      t0_q <= t0_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // wake detect on pins 1.3/1.4, timed in oscillator ticks
  localparam int unsigned OSC_CNT_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  logic [OSC_CNT_W-1:0] osc_div_q;
  logic osc_tick;
  pfm_pkg::pfm_wake_state_t wk_state_q;
  logic [1:0] wk_ref_q;
  logic [2:0] wk_cnt_q;
  logic wake_q;
  logic [1:0] wk_diff;

  assign osc_tick = (osc_div_q == OSC_CNT_W'(OSC_DIV - 1));
  assign wk_diff = (pin_q[1:0] ^ wk_ref_q) & p1_in_enable;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      osc_div_q <= '0;
    else if (osc_tick)
      osc_div_q <= '0;
    else
      osc_div_q <= osc_div_q + OSC_CNT_W'(1);
  end

  // a glitch shorter than the hold restarts the count, so noise cannot wake
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wk_state_q <= pfm_pkg::WK_IDLE;
      wk_ref_q <= 2'h0;
      wk_cnt_q <= 3'h0;
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= 1'b0;
      case (wk_state_q)
        pfm_pkg::WK_IDLE:
        begin
          wk_ref_q <= pin_q[1:0];
          wk_cnt_q <= 3'h0;
          if (sleep_active && (|p1_in_enable))
            wk_state_q <= pfm_pkg::WK_TRACK;
        end
        pfm_pkg::WK_TRACK:
        begin
          if (!sleep_active)
            wk_state_q <= pfm_pkg::WK_IDLE;
          else if (wk_diff == 2'h0)
            wk_cnt_q <= 3'h0;
          else if (osc_tick)
          begin
            if (wk_cnt_q == 3'(pfm_pkg::WAKE_HOLD_OSC - 1))
            begin
              wake_q <= 1'b1;
              wk_state_q <= pfm_pkg::WK_FIRE;
            end
            else
              wk_cnt_q <= wk_cnt_q + 3'h1;
          end
        end
        pfm_pkg::WK_FIRE:
          wk_state_q <= pfm_pkg::WK_IDLE;
        default:
          wk_state_q <= pfm_pkg::WK_IDLE;
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign p1_pin_level = p1_level_q;
  assign p1_pad_out = p1_out_q;
  assign p1_pad_oe = p1_oe_q;
  assign p2_pad_out = p2_out_q;
  assign p2_pad_oe = p2_oe_q;
  assign uart_five_receive = u5_rx_q;
  assign uart_four_receive = u4_rx_q;
  assign timer_two_ext_input = t2_q;
  assign timer_zero_ext_input = t0_q;
  assign io_irq_input = irq_q;
  assign wake_pulse = wake_q;

endmodule

// ==== rtl/pfm_pkg.sv ====
// constants, codes and register map of the port one/two function mux
package pfm_pkg;

  // ==========================================================
  // register map: printed offsets are word indices, byte address is four times the index
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] IDX_G2_OUT_DIS = 16'h28b0;
  localparam logic [15:0] IDX_G2_IN_EN = 16'h28b1;
  localparam logic [15:0] IDX_G2_OUT_VAL = 16'h28b2;
  localparam logic [15:0] IDX_G2_LEVEL = 16'h28b3;
  localparam logic [15:0] IDX_P13_SEL = 16'h28c7;
  localparam logic [15:0] IDX_P14_SEL = 16'h28c8;
  localparam logic [15:0] IDX_P20_SEL = 16'h28c9;
  localparam logic [15:0] IDX_P21_SEL = 16'h28ca;
  localparam logic [15:0] IDX_PWR_CTRL = 16'h2d00;

  // ==========================================================
  // field positions and widths
  localparam int unsigned G2_PINS = 6;
  localparam int unsigned P13_SEL_W = 3;
  localparam int unsigned PX_SEL_W = 2;
  localparam int unsigned GATE_BIT = 3;
  localparam int unsigned PWR_CTRL_W = 8;

  // ==========================================================
  // reset values
  localparam logic [5:0] RST_G2_OUT_DIS = 6'h3f;
  localparam logic [5:0] RST_G2_IN_EN = 6'h00;
  localparam logic [5:0] RST_G2_OUT_VAL = 6'h3f;
  localparam logic [5:0] RST_G2_LEVEL = 6'h00;
  localparam logic [2:0] RST_P13_SEL = 3'h0;
  localparam logic [1:0] RST_PX_SEL = 2'h0;
  localparam logic [7:0] RST_PWR_CTRL = 8'h00;

  // ==========================================================
  // timing
  localparam int unsigned WAKE_HOLD_OSC = 4;
  localparam int unsigned OSC_DIV_DEFAULT = 1;

  // ==========================================================
  // route codes
  typedef enum logic [2:0] {
    P13_GPIO = 3'h0,
    P13_E2_PULSE = 3'h1,
    P13_UART5_RX = 3'h2,
    P13_IRQ0 = 3'h3,
    P13_E1_PULSE = 3'h4,
    P13_SECOND = 3'h5,
    P13_PLL_DIV = 3'h6
  } pfm_p13_code_t;

  typedef enum logic [1:0] {
    P14_GPIO = 2'h0,
    P14_PLL_DIV = 2'h1,
    P14_UART5_TX = 2'h2,
    P14_IRQ1 = 2'h3
  } pfm_p14_code_t;

  typedef enum logic [1:0] {
    P20_GPIO = 2'h0,
    P20_OSC = 2'h1,
    P20_UART4_RX = 2'h2,
    P20_TIMER2 = 2'h3
  } pfm_p20_code_t;

  typedef enum logic [1:0] {
    P21_GPIO = 2'h0,
    P21_UART4_TX = 2'h2,
    P21_TIMER0 = 2'h3
  } pfm_p21_code_t;

  // wake detector, gray along idle -> track -> wake
  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_TRACK = 2'h1,
    WK_FIRE = 2'h3
  } pfm_wake_state_t;

endpackage

// ==== tb/pfm_port_mux_asserts.sv ====
// concurrent checks on the port function mux, bound onto the design
module pfm_chk #(
  parameter int unsigned OSC_DIV = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and sinks
  input wire logic [1:0] p1_in_enable,
  input wire logic [1:0] p1_pin_level,
  input wire logic [1:0] p1_pad_oe,
  input wire logic [5:0] p2_pad_oe,
  input wire logic uart_five_receive,
  input wire logic [1:0] io_irq_input,
  // wake
  input wire logic sleep_active,
  input wire logic wake_pulse
);
  // ==========================================================
  // address decode, kept apart from the design's own
  logic [15:0] idx;
  logic mapped;
  assign idx = paddr[17:2];
  assign mapped = (idx >= pfm_pkg::IDX_G2_OUT_DIS && idx <= pfm_pkg::IDX_G2_LEVEL)
    || (idx >= pfm_pkg::IDX_P13_SEL && idx <= pfm_pkg::IDX_P21_SEL) || idx == pfm_pkg::IDX_PWR_CTRL;

  // ==========================================================
  // properties
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing one cycle into access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag outside a completion");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside completion");
  a_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("error flag does not match address decode");
  a_reset_state: assert property ($fell(srst) |-> !pready && p1_pad_oe == 2'h0 && p2_pad_oe == 6'h00
    && uart_five_receive && io_irq_input == 2'h0 && !wake_pulse)
    else $error("outputs not at reset state after reset");
  a_level_hold: assert property (!p1_in_enable[0] |=> p1_pin_level[0] == $past(p1_pin_level[0]))
    else $error("pin level moved with input disabled");
  a_wake_single: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse longer than one cycle");
  a_wake_asleep: assert property (wake_pulse |-> $past(sleep_active, 2))
    else $error("wake pulse without sleep");
endmodule

bind pfm_port_mux pfm_chk #(.OSC_DIV(OSC_DIV)) chk_u (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .p1_in_enable(p1_in_enable), .p1_pin_level(p1_pin_level),
  .p1_pad_oe(p1_pad_oe), .p2_pad_oe(p2_pad_oe), .uart_five_receive(uart_five_receive),
  .io_irq_input(io_irq_input), .sleep_active(sleep_active), .wake_pulse(wake_pulse)
);

// ==== tb/port_p1_p2_function_mux_tb.sv ====
// self-checking bench for the port one/two function mux
module port_p1_p2_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and wiring
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] p1_out_disable = 2'h3;
  logic [1:0] p1_in_enable = 2'h0;
  logic [1:0] p1_out_value = 2'h1;
  logic [7:0] pin_in = 8'h00;
  logic [6:0] src = 7'h00;
  logic sleep_active = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, wake_pulse;
  logic [1:0] p1_pin_level, p1_pad_out, p1_pad_oe;
  logic [5:0] p2_pad_out, p2_pad_oe;
  wire logic [5:0] sink;
  wire logic [7:0] pad_out = {p2_pad_out, p1_pad_out};
  wire logic [7:0] pad_oe = {p2_pad_oe, p1_pad_oe};
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  pfm_port_mux #(.OSC_DIV(1)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .p1_out_disable(p1_out_disable),
    .p1_in_enable(p1_in_enable), .p1_out_value(p1_out_value), .p1_pin_level(p1_pin_level),
    .p1_pad_in(pin_in[1:0]), .p1_pad_out(p1_pad_out), .p1_pad_oe(p1_pad_oe), .p2_pad_in(pin_in[7:2]),
    .p2_pad_out(p2_pad_out), .p2_pad_oe(p2_pad_oe), .energy_path1_pulse(src[0]), .energy_path2_pulse(src[1]),
    .second_pulse_out(src[2]), .divided_pll_pulse(src[3]), .reference_clock_waveform(src[4]),
    .uart_five_transmit(src[5]), .uart_four_transmit(src[6]), .io_irq_input(sink[1:0]),
    .uart_five_receive(sink[2]), .uart_four_receive(sink[3]), .timer_two_ext_input(sink[4]),
    .timer_zero_ext_input(sink[5]), .sleep_active(sleep_active), .wake_pulse(wake_pulse)
  );

  initial forever #2 ref_clk = ~ref_clk;

  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    chk("apb_wait", 32'h0, 32'(n == 50));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    chk("write_err", 32'h0, 32'(e));
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(nm, exp, r);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_map();
    logic [31:0] r;
    logic e;
    chk("oe_reset", 32'h0, 32'(pad_oe));
    rd_chk("out_dis", pfm_pkg::IDX_G2_OUT_DIS, 32'h3f);
    rd_chk("in_en", pfm_pkg::IDX_G2_IN_EN, 32'h00);
    rd_chk("out_val", pfm_pkg::IDX_G2_OUT_VAL, 32'h3f);
    rd_chk("level", pfm_pkg::IDX_G2_LEVEL, 32'h00);
    rd_chk("sel13", pfm_pkg::IDX_P13_SEL, 32'h0);
    rd_chk("sel14", pfm_pkg::IDX_P14_SEL, 32'h0);
    rd_chk("sel20", pfm_pkg::IDX_P20_SEL, 32'h0);
    rd_chk("sel21", pfm_pkg::IDX_P21_SEL, 32'h0);
    wr(pfm_pkg::IDX_P13_SEL, 32'hff);
    rd_chk("sel13_mask", pfm_pkg::IDX_P13_SEL, 32'h07);
    wr(pfm_pkg::IDX_P14_SEL, 32'hff);
    rd_chk("sel14_mask", pfm_pkg::IDX_P14_SEL, 32'h03);
    apb(1'b1, 16'h28b4, 32'h5, r, e);
    chk("unmapped_wr", 32'h1, 32'(e));
    apb(1'b0, 16'h28b4, 32'h0, r, e);
    chk("unmapped_rd", 32'h1, 32'(e));
  endtask

  // entry nibbles: pin, code, kind (0 gpio, 1 output, 2 input), source or sink bit
  task automatic route_case(input logic [15:0] e);
    string nm;
    logic [1:0] pin;
    logic [2:0] b;
    nm = $sformatf("route_%h", e);
    pin = e[13:12];
    b = e[2:0];
    wr(pfm_pkg::IDX_P13_SEL + {14'h0, pin}, {28'h0, e[11:8]});
    repeat (2) @(posedge ref_clk);
    if (e[7:4] == 4'h0)
    begin
      chk(nm, 32'h1, 32'(pad_oe[pin]));
      chk(nm, {31'h0, ~pin[0]}, 32'(pad_out[pin]));
    end
    else if (e[7:4] == 4'h1)
    begin
      src <= 7'h01 << b;
      repeat (2) @(posedge ref_clk);
      chk(nm, 32'h1, 32'(pad_oe[pin]));
      chk(nm, 32'h1, 32'(pad_out[pin]));
      src <= ~(7'h01 << b);
      repeat (2) @(posedge ref_clk);
      chk(nm, 32'h0, 32'(pad_out[pin]));
    end
    else
    begin
      pin_in[pin] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(nm, 32'h0, 32'(pad_oe[pin]));
      chk(nm, 32'h0, 32'(sink[b]));
      pin_in[pin] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(nm, 32'h1, 32'(sink[b]));
    end
  endtask

  task automatic t_routes();
    logic [15:0] rt [20] = '{16'h0000, 16'h0111, 16'h0222, 16'h0320, 16'h0410,
      16'h0512, 16'h0613, 16'h0700, 16'h1000, 16'h1113, 16'h1215, 16'h1321,
      16'h2000, 16'h2114, 16'h2223, 16'h2324,
      16'h3000, 16'h3100, 16'h3216, 16'h3325};
    foreach (rt[i]) route_case(rt[i]);
  endtask

  task automatic t_gate();
    wr(pfm_pkg::IDX_PWR_CTRL, 32'h08);
    rd_chk("pwr", pfm_pkg::IDX_PWR_CTRL, 32'h08);
    repeat (2) @(posedge ref_clk);
    chk("gate_p2", 32'h0, 32'(pad_oe[7:4]));
    chk("gate_p13", 32'h0, 32'(pad_oe[0]));
    src <= 7'h10;
    wr(pfm_pkg::IDX_P20_SEL, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("gate_spec_oe", 32'h1, 32'(pad_oe[2]));
    chk("gate_spec_out", 32'h1, 32'(pad_out[2]));
    wr(pfm_pkg::IDX_PWR_CTRL, 32'h00);
    repeat (2) @(posedge ref_clk);
    chk("ungate_p2", 32'hf, 32'(pad_oe[7:4]));
    chk("out_val_p2", 32'h0, 32'(pad_out[7:4]));
  endtask

  task automatic t_level();
    wr(pfm_pkg::IDX_G2_IN_EN, 32'h05);
    pin_in[7:2] <= 6'h2d;
    repeat (8) @(posedge ref_clk);
    rd_chk("level_live", pfm_pkg::IDX_G2_LEVEL, 32'h05);
    // inputs off first, or the next capture would hide a stray write
    wr(pfm_pkg::IDX_G2_IN_EN, 32'h00);
    wr(pfm_pkg::IDX_G2_LEVEL, 32'h00);
    pin_in[7:2] <= 6'h28;
    repeat (8) @(posedge ref_clk);
    rd_chk("level_nowr", pfm_pkg::IDX_G2_LEVEL, 32'h05);
    wr(pfm_pkg::IDX_G2_IN_EN, 32'h05);
    repeat (8) @(posedge ref_clk);
    rd_chk("level_follow", pfm_pkg::IDX_G2_LEVEL, 32'h00);
    wr(pfm_pkg::IDX_G2_IN_EN, 32'h00);
  endtask

  task automatic t_wake();
    int n;
    n = 0;
    pin_in[1:0] <= 2'h2;
    p1_in_enable <= 2'h3;
    repeat (10) @(posedge ref_clk);
    sleep_active <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("p1_level_low", 32'h0, 32'(p1_pin_level[0]));
    pin_in[0] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    pin_in[0] <= 1'b0;
    repeat (20) @(posedge ref_clk) n += 32'(wake_pulse === 1'b1);
    chk("wake_glitch", 32'h0, 32'(n));
    pin_in[0] <= 1'b1;
    repeat (20) @(posedge ref_clk) n += 32'(wake_pulse === 1'b1);
    chk("wake_edge", 32'h1, 32'(n));
    chk("p1_level_high", 32'h1, 32'(p1_pin_level[0]));
    pin_in[0] <= 1'b0;
    repeat (20) @(posedge ref_clk) n += 32'(wake_pulse === 1'b1);
    chk("wake_fall", 32'h2, 32'(n));
    pin_in[1] <= 1'b0;
    repeat (20) @(posedge ref_clk) n += 32'(wake_pulse === 1'b1);
    chk("wake_pin14", 32'h3, 32'(n));
    sleep_active <= 1'b0;
  endtask

  // ==========================================================
  // main sequence and hang guard
  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_reset_map();
    p1_out_disable <= 2'h0;
    wr(pfm_pkg::IDX_G2_OUT_DIS, 32'h00);
    wr(pfm_pkg::IDX_G2_OUT_VAL, 32'h01);
    t_routes();
    t_gate();
    t_level();
    t_wake();
    give_verdict();
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end
endmodule
